// ==== hw/dfs_capture.sv ====
// Purpose: builds the 64-bit fault record from one data MMU event
// Assumes: inputs are from core logic on the same clock
// Notes:   pure combinational; the top registers the result
`timescale 1ns/1ps
`include "dfs_cfg.svh"

module dfs_capture
	import dfs_pkg::*;
(
	input  wire logic [1:0]  kind,
	input  wire logic        space_explicit,
	input  wire logic [7:0]  space_in,
	input  wire logic        trap_level_nz,
	input  wire logic        default_little_endian,
	input  wire logic        space_translating,
	input  wire logic [1:0]  ctx_in,
	input  wire logic        uncorrectable,
	input  wire logic        bus_error,
	input  wire logic        bus_timeout,
	input  wire logic        multi_hit,
	input  wire logic        noncacheable,
	input  wire logic        side_effect_page,
	input  wire logic        nonfault_load,
	input  wire logic        privileged,
	input  wire logic        is_write,
	input  wire logic [6:0]  fault_type,
	input  wire logic        prior_valid,
	output logic      [63:0] record
);

	logic [7:0] space_used;
	logic       is_error;

	always_comb begin
		record   = `DFS_STATUS_RESET;
		is_error = (kind == DFS_KIND_ERROR);
		// Implied space identifier from trap level and endianness
		if (space_explicit) begin
			space_used = space_in;
		end else if (!trap_level_nz) begin
			space_used = default_little_endian ? `DFS_SPACE_PRIM_LIT : `DFS_SPACE_PRIM_BIG;
		end else begin
			space_used = default_little_endian ? `DFS_SPACE_NUC_LIT : `DFS_SPACE_NUC_BIG;
		end
		record[`DFS_SPACE_HI:`DFS_SPACE_LO] = space_used;
		// Caller passes the instruction's own context and the effective one on shared hits
		record[`DFS_CTXSEL_HI:`DFS_CTXSEL_LO] =
			space_translating ? ctx_in : DFS_CTX_NONXLATE;
		record[`DFS_BIT_PRIV]      = privileged;
		record[`DFS_BIT_W]         = is_write;
		record[`DFS_BIT_NONFAULT]  = nonfault_load;
		record[`DFS_BIT_OVERWRITE] = prior_valid;
		if (kind == DFS_KIND_MISS) begin
			record[`DFS_BIT_TLB_MISS] = 1'b1;
		end else begin
			record[`DFS_BIT_VALID] = 1'b1;
		end
		if (kind == DFS_KIND_EXCEPTION) begin
			record[`DFS_FTYPE_HI:`DFS_FTYPE_LO] = fault_type;
		end
		if (is_error) begin
			record[`DFS_BIT_UNCORR]  = uncorrectable;
			record[`DFS_BIT_BUS_ERR] = bus_error;
			record[`DFS_BIT_BTO]     = bus_timeout;
			record[`DFS_BIT_MHIT_HI] = multi_hit;
			record[`DFS_BIT_MHIT_LO] = 1'b0;
			// Side-effect and noncacheable only mean something for these causes
			if (uncorrectable || bus_error || bus_timeout) begin
				record[`DFS_BIT_NC] = noncacheable;
				record[`DFS_BIT_SE] = side_effect_page || (space_used == `DFS_SPACE_SE_A)
					|| (space_used == `DFS_SPACE_SE_B);
			end
		end
	end

endmodule // dfs_capture

// ==== hw/dfs_cfg.svh ====
// Purpose: offsets, field positions, reset values and codes of the data fault status block
// Assumes: APB with 32-bit data; the 64-bit register is split into two aligned words
// Notes:   included by the design modules and by the bench
`ifndef DFS_CFG_SVH
`define DFS_CFG_SVH

// ==========================================================================
// Register map
`define DFS_OFF_STATUS_LO   12'h000
`define DFS_OFF_STATUS_HI   12'h004
`define DFS_OFF_FAULT_COUNT 12'h008
`define DFS_STATUS_RESET    64'h0000000000000000

// ==========================================================================
// Field positions
`define DFS_BIT_UNCORR      31
`define DFS_BIT_BUS_ERR     30
`define DFS_BIT_BTO         29
`define DFS_BIT_MHIT_HI     27
`define DFS_BIT_MHIT_LO     26
`define DFS_BIT_NC          25
`define DFS_BIT_NONFAULT    24
`define DFS_SPACE_HI        23
`define DFS_SPACE_LO        16
`define DFS_BIT_TLB_MISS    15
`define DFS_FTYPE_HI        13
`define DFS_FTYPE_LO        7
`define DFS_BIT_SE          6
`define DFS_CTXSEL_HI       5
`define DFS_CTXSEL_LO       4
`define DFS_BIT_PRIV        3
`define DFS_BIT_W           2
`define DFS_BIT_OVERWRITE   1
`define DFS_BIT_VALID       0

// ==========================================================================
// Implied space identifiers and side-effect spaces
`define DFS_SPACE_PRIM_BIG  8'h80
`define DFS_SPACE_PRIM_LIT  8'h88
`define DFS_SPACE_NUC_BIG   8'h04
`define DFS_SPACE_NUC_LIT   8'h0C
`define DFS_SPACE_SE_A      8'h15
`define DFS_SPACE_SE_B      8'h1D

// ==========================================================================
// Fault type bit positions within the seven-bit field
`define DFS_FTYPE_PRIV      0
`define DFS_FTYPE_NOFLT_SE  1
`define DFS_FTYPE_ATOM_NC   2
`define DFS_FTYPE_INVALID   3
`define DFS_FTYPE_NOFLT_PG  4

`endif

// ==== hw/dfs_pkg.sv ====
// Purpose: types shared by the data fault status block
// Assumes: constants come from dfs_cfg.svh
// Notes:   context codes and fault kinds
package dfs_pkg;

	// ==========================================================================
	// Context select codes
	typedef enum logic [1:0] {
		DFS_CTX_PRIMARY   = 2'h0,
		DFS_CTX_SECONDARY = 2'h1,
		DFS_CTX_NUCLEUS   = 2'h2,
		DFS_CTX_NONXLATE  = 2'h3
	} dfs_ctx_t;

	// ==========================================================================
	// Kind of data MMU event presented by the core
	typedef enum logic [1:0] {
		DFS_KIND_MISS      = 2'h0,
		DFS_KIND_EXCEPTION = 2'h1,
		DFS_KIND_ERROR     = 2'h2
	} dfs_kind_t;

endpackage

// ==== hw/dfs_status.sv ====
// Purpose: data MMU fault status register with capture port and APB access
// Assumes: single clock pclk at 250 MHz; event inputs come from core logic on pclk
// Notes:   64-bit register is two APB words; a write to a word replaces only the bytes enabled by pstrb
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "dfs_cfg.svh"

module dfs_status
	import dfs_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        evt_valid,
	input  wire logic [1:0]  evt_kind,
	input  wire logic        evt_space_explicit,
	input  wire logic [7:0]  evt_space_id,
	input  wire logic        trap_level_nz,
	input  wire logic        default_little_endian,
	input  wire logic        evt_space_translating,
	input  wire logic [1:0]  evt_context,
	input  wire logic        evt_uncorrectable,
	input  wire logic        evt_bus_error,
	input  wire logic        evt_bus_timeout,
	input  wire logic        evt_multi_hit,
	input  wire logic        evt_noncacheable,
	input  wire logic        evt_side_effect,
	input  wire logic        evt_nonfault_load,
	input  wire logic        evt_privileged,
	input  wire logic        evt_write,
	input  wire logic [6:0]  evt_fault_type,
	output logic             fault_valid_flag,
	output logic             overwrite_flag
);

	// ==========================================================================
	// State
	typedef struct packed {
		logic [63:0] data_fault_status;
		logic [31:0] fault_count;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        fault_valid_flag;
		logic        overwrite_flag;
	} dfs_state_t;

	dfs_state_t s_q;
	dfs_state_t s_d;
	logic [63:0] record;

	// ==========================================================================
	// Helpers
	function automatic logic [31:0] dfs_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] m;
		m = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// ==========================================================================
	// Record builder
	dfs_capture u_capture (
		.kind                  (evt_kind),
		.space_explicit        (evt_space_explicit),
		.space_in              (evt_space_id),
		.trap_level_nz         (trap_level_nz),
		.default_little_endian (default_little_endian),
		.space_translating     (evt_space_translating),
		.ctx_in                (evt_context),
		.uncorrectable         (evt_uncorrectable),
		.bus_error             (evt_bus_error),
		.bus_timeout           (evt_bus_timeout),
		.multi_hit             (evt_multi_hit),
		.noncacheable          (evt_noncacheable),
		.side_effect_page      (evt_side_effect),
		.nonfault_load         (evt_nonfault_load),
		.privileged            (evt_privileged),
		.is_write              (evt_write),
		.fault_type            (evt_fault_type),
		.prior_valid           (s_q.data_fault_status[`DFS_BIT_VALID]),
		.record                (record)
	);

	// ==========================================================================
	// Next state
	always_comb begin
		logic setup;
		logic access;
		logic hit_lo;
		logic hit_hi;
		logic hit_cnt;
		setup   = psel && !penable;
		access  = psel && penable;
		hit_lo  = (paddr == `DFS_OFF_STATUS_LO);
		hit_hi  = (paddr == `DFS_OFF_STATUS_HI);
		hit_cnt = (paddr == `DFS_OFF_FAULT_COUNT);
		s_d = s_q;
		// Zero-wait: pready rises in the access cycle, one cycle after setup
		s_d.pready  = setup;
		s_d.pslverr = setup && !(hit_lo || hit_hi || hit_cnt);
		if (setup && !pwrite) begin
			unique case (1'b1)
				hit_lo:  s_d.prdata = s_q.data_fault_status[31:0];
				hit_hi:  s_d.prdata = s_q.data_fault_status[63:32];
				hit_cnt: s_d.prdata = s_q.fault_count;
				default: s_d.prdata = 32'h00000000;
			endcase
		end
		if (access && s_q.pready && pwrite) begin
			if (hit_lo) begin
				s_d.data_fault_status[31:0] =
					dfs_merge(s_q.data_fault_status[31:0], pwdata, pstrb);
			end
			if (hit_hi) begin
				s_d.data_fault_status[63:32] =
					dfs_merge(s_q.data_fault_status[63:32], pwdata, pstrb);
			end
			if (hit_cnt) begin
				s_d.fault_count = dfs_merge(s_q.fault_count, pwdata, pstrb);
			end
		end
		// A new fault wins over a software write in the same cycle
		if (evt_valid) begin
			s_d.data_fault_status = record;
			s_d.fault_count       = s_q.fault_count + 32'h00000001;
		end
		// Flag copies follow the register at the same edge
		s_d.fault_valid_flag = s_d.data_fault_status[`DFS_BIT_VALID];
		s_d.overwrite_flag   = s_d.data_fault_status[`DFS_BIT_OVERWRITE];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign prdata           = s_q.prdata;
	assign pready           = s_q.pready;
	assign pslverr          = s_q.pslverr;
	assign fault_valid_flag = s_q.fault_valid_flag;
	assign overwrite_flag   = s_q.overwrite_flag;

endmodule // dfs_status

// ==== tb/dfs_status_sva.sv ====
// Purpose: port-level checks of the data fault status block
// Assumes: one clock pclk, presetn asynchronous and active low
// Notes:   flag outputs change at the same edge as the register
`timescale 1ns/1ps

module dfs_status_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        evt_valid,
	input wire logic [1:0]  evt_kind,
	input wire logic        fault_valid_flag,
	input wire logic        overwrite_flag
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================================
	// Register bus
	ready_pulse_a: assert property (
		psel && !penable && clk_en ##1 clk_en |-> pready ##1 !pready)
		else $error("pready not a single cycle after setup");
	unmapped_err_a: assert property (
		psel && !penable && clk_en && paddr > 12'h008 |=> pslverr && pready)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (
		psel && !penable && clk_en && paddr inside {12'h000, 12'h004, 12'h008} |=> !pslverr)
		else $error("mapped access refused");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr outside access cycle");

	// ==========================================================================
	// Capture; the flag copies are loaded at the capturing edge itself
	miss_clears_valid_a: assert property (
		evt_valid && clk_en && evt_kind == 2'h0 |=> !fault_valid_flag)
		else $error("miss left fault valid set");
	fault_sets_valid_a: assert property (
		evt_valid && clk_en && evt_kind != 2'h0 |=> fault_valid_flag)
		else $error("fault did not set fault valid");
	overwrite_copy_a: assert property (
		evt_valid && clk_en |=> overwrite_flag == $past(fault_valid_flag))
		else $error("overwrite flag not prior fault valid");
	freeze_hold_a: assert property (
		!clk_en |=> $stable(fault_valid_flag) && $stable(overwrite_flag))
		else $error("flags moved while frozen");
endmodule // dfs_status_sva

bind dfs_status dfs_status_sva i_dfs_status_sva (.pclk, .presetn, .clk_en, .psel, .penable,
	.paddr, .pready, .pslverr, .evt_valid, .evt_kind, .fault_valid_flag, .overwrite_flag);

// ==== tb/dfs_status_tb_top.sv ====
// Purpose: self-checking bench for the data fault status block
// Assumes: APB master with one transfer at a time
// Notes:   expected records are rebuilt from the event fields
`timescale 1ns/1ps
`include "dfs_cfg.svh"

module dfs_status_tb_top
	import dfs_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn, clk_en, psel, penable, pwrite, evt_valid, err, vld_m;
	logic        pready, pslverr, fault_valid_flag, overwrite_flag;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, f, lo_m;
	logic [3:0]  pstrb;
	wire  [1:0]  evt_kind, evt_context;
	wire  [7:0]  evt_space_id;
	wire  [6:0]  evt_fault_type;
	wire         evt_space_explicit, trap_level_nz, default_little_endian, evt_space_translating;
	wire         evt_uncorrectable, evt_bus_error, evt_bus_timeout, evt_multi_hit;
	wire         evt_noncacheable, evt_side_effect, evt_nonfault_load, evt_privileged, evt_write;
	int          n_mismatch, checks_done;

	// One vector feeds every event field, so a field set never straddles an edge
	assign {evt_kind, evt_space_id, evt_space_explicit, trap_level_nz, default_little_endian,
		evt_space_translating, evt_context, evt_uncorrectable, evt_bus_error, evt_bus_timeout,
		evt_multi_hit, evt_noncacheable, evt_side_effect, evt_nonfault_load, evt_privileged,
		evt_write, evt_fault_type} = f;

	dfs_status i_dfs_status (
		.pclk                  (pclk),
		.presetn               (presetn),
		.clk_en                (clk_en),
		.psel                  (psel),
		.penable               (penable),
		.pwrite                (pwrite),
		.paddr                 (paddr),
		.pwdata                (pwdata),
		.pstrb                 (pstrb),
		.prdata                (prdata),
		.pready                (pready),
		.pslverr               (pslverr),
		.evt_valid             (evt_valid),
		.evt_kind              (evt_kind),
		.evt_space_explicit    (evt_space_explicit),
		.evt_space_id          (evt_space_id),
		.trap_level_nz         (trap_level_nz),
		.default_little_endian (default_little_endian),
		.evt_space_translating (evt_space_translating),
		.evt_context           (evt_context),
		.evt_uncorrectable     (evt_uncorrectable),
		.evt_bus_error         (evt_bus_error),
		.evt_bus_timeout       (evt_bus_timeout),
		.evt_multi_hit         (evt_multi_hit),
		.evt_noncacheable      (evt_noncacheable),
		.evt_side_effect       (evt_side_effect),
		.evt_nonfault_load     (evt_nonfault_load),
		.evt_privileged        (evt_privileged),
		.evt_write             (evt_write),
		.evt_fault_type        (evt_fault_type),
		.fault_valid_flag      (fault_valid_flag),
		.overwrite_flag        (overwrite_flag)
	);

	always #2 pclk = ~pclk;

	// ==========================================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// m = {explicit, level nonzero, little endian, translating}; er = {ue, bus_error_flag, bto, mhit, nc, se}
	task automatic ev(input logic [1:0] k, input logic [7:0] a, input logic [3:0] m,
		input logic [1:0] c, input logic [5:0] er, input logic [2:0] pw, input logic [6:0] ft);
		logic [31:0] e;
		logic [31:0] mk;
		logic [7:0]  s;
		logic        cz;
		s = m[3] ? a : ((m[2] ? 8'h04 : 8'h80) | {4'h0, m[1], 3'h0});
		cz = k == DFS_KIND_ERROR && (|er[5:3]);
		e = '0;
		e[15] = k == DFS_KIND_MISS;
		e[0] = !e[15];
		e[1] = vld_m;
		e[5:4] = m[0] ? c : 2'h3;
		{e[24], e[3], e[2]} = pw;
		e[23:16] = s;
		if (k == DFS_KIND_EXCEPTION) e[13:7] = ft;
		if (k == DFS_KIND_ERROR) {e[31:29], e[27]} = er[5:2];
		e[25] = cz && er[1];
		e[6] = cz && (er[0] || s == 8'h15 || s == 8'h1D);
		// A miss defines only its own fields
		mk = e[15] ? 32'h0100_803D : 32'hFFFF_FFFF;
		@(posedge pclk);
		f <= {k, a, m, c, er, pw, ft};
		evt_valid <= 1'b1;
		@(posedge pclk);
		evt_valid <= 1'b0;
		apb(1'b0, `DFS_OFF_STATUS_LO, 32'h0);
		chk("status_lo", e & mk, rd & mk);
		apb(1'b0, `DFS_OFF_STATUS_HI, 32'h0);
		chk("status_hi", 32'h0, rd);
		chk("flags", e[1:0], {overwrite_flag, fault_valid_flag});
		vld_m = e[0];
		lo_m = e;
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// ==========================================================================
	// Tests
	initial begin
		{presetn, psel, penable, pwrite, evt_valid, vld_m} = '0;
		{f, paddr, pwdata, lo_m} = '0;
		clk_en = 1'b1;
		pstrb = 4'hF;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `DFS_OFF_STATUS_LO, 32'h0);
		chk("reset_lo", 32'h0, rd);
		chk("reset_flags", 32'h0, {overwrite_flag, fault_valid_flag});
		$display("test reset done");
		ev(DFS_KIND_MISS, 8'h00, 4'h9, 2'h1, 6'h00, 3'h7, 7'h00);
		ev(DFS_KIND_EXCEPTION, 8'h55, 4'h1, 2'h0, 6'h00, 3'h2, 7'h1F);
		ev(DFS_KIND_EXCEPTION, 8'h55, 4'h3, 2'h1, 6'h00, 3'h1, 7'h09);
		ev(DFS_KIND_EXCEPTION, 8'h00, 4'h5, 2'h2, 6'h00, 3'h4, 7'h02);
		ev(DFS_KIND_EXCEPTION, 8'h00, 4'h6, 2'h2, 6'h00, 3'h0, 7'h08);
		ev(DFS_KIND_ERROR, 8'h3A, 4'h9, 2'h2, 6'h3F, 3'h0, 7'h00);
		ev(DFS_KIND_ERROR, 8'h1D, 4'h9, 2'h0, 6'h08, 3'h0, 7'h00);
		ev(DFS_KIND_ERROR, 8'h15, 4'h8, 2'h1, 6'h20, 3'h1, 7'h00);
		ev(DFS_KIND_ERROR, 8'h20, 4'h9, 2'h1, 6'h04, 3'h0, 7'h00);
		ev(DFS_KIND_MISS, 8'h00, 4'h9, 2'h0, 6'h00, 3'h0, 7'h00);
		$display("test capture done");
		apb(1'b1, `DFS_OFF_STATUS_LO, 32'h0234_1679);
		apb(1'b0, `DFS_OFF_STATUS_LO, 32'h0);
		chk("write_lo", 32'h0234_1679, rd);
		apb(1'b1, `DFS_OFF_STATUS_HI, 32'hA5A5_5A5A);
		apb(1'b0, `DFS_OFF_STATUS_HI, 32'h0);
		chk("write_hi", 32'hA5A5_5A5A, rd);
		vld_m = 1'b1;
		ev(DFS_KIND_EXCEPTION, 8'h42, 4'h9, 2'h1, 6'h00, 3'h0, 7'h01);
		apb(1'b1, `DFS_OFF_STATUS_LO, 32'h0);
		vld_m = 1'b0;
		ev(DFS_KIND_EXCEPTION, 8'h42, 4'h9, 2'h0, 6'h00, 3'h0, 7'h10);
		$display("test software done");
		apb(1'b1, 12'h010, 32'hFFFF_FFFF);
		chk("wr_slverr", 32'h1, err);
		apb(1'b0, 12'h010, 32'h0);
		chk("rd_slverr", 32'h1, err);
		chk("rd_unmapped", 32'h0, rd);
		@(posedge pclk);
		clk_en <= 1'b0;
		evt_valid <= 1'b1;
		@(posedge pclk);
		evt_valid <= 1'b0;
		@(posedge pclk);
		clk_en <= 1'b1;
		apb(1'b0, `DFS_OFF_STATUS_LO, 32'h0);
		chk("lo_kept", lo_m, rd);
		// Twelve captured events; the frozen one must not count
		apb(1'b0, `DFS_OFF_FAULT_COUNT, 32'h0);
		chk("fault_count", 32'h0000_000C, rd);
		$display("test refuse and freeze done");
		test_done;
	end

	initial begin
		#20000;
		n_mismatch++;
		test_done;
	end
endmodule // dfs_status_tb_top
